// [hdl/csp_pin_assign.sv]
// select pin unit: pin assignment, boot and general base/option registers
// assumes: one AHB-Lite master, hclk 10 MHz, strap pins asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "csp_map.svh"
module csp_pin_assign (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] strap_data,
    input wire logic [11:0] select_src,
    input wire logic [23:19] addr_src,
    input wire logic [2:0] function_code_line,
    input wire logic bus_request,
    input wire logic bus_grant,
    input wire logic bus_grant_acknowledge,
    input wire logic slow_bus_eclock,
    output logic [11:0] select_pin,
    output logic [11:0] select_mode,
    output logic [10:0] channel_enable
);
    // ----------------------------------------------------------
    // strap synchroniser and capture
    // ----------------------------------------------------------
    logic [7:0] strap_meta_ff;
    logic [7:0] strap_sync_ff;
    logic [1:0] rst_seen_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_meta_ff <= 8'hFF;
            strap_sync_ff <= 8'hFF;
        end else begin
            strap_meta_ff <= strap_data;
            strap_sync_ff <= strap_meta_ff;
        end
    end
    // straps are captured on the third edge after release, once synchronised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_seen_ff <= 2'h0;
        end else if (rst_seen_ff != 2'h3) begin
            rst_seen_ff <= rst_seen_ff + 2'h1;
        end
    end
    logic strap_load;
    assign strap_load = (rst_seen_ff == 2'h2);

    // ----------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------
    csp_pkg::csp_state_t state_ff;
    logic [11:0] addr_ff;
    logic take;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= csp_pkg::CSP_ST_IDLE;
            addr_ff <= 12'h000;
        end else begin
            if (take) begin
                addr_ff <= haddr[11:0];
            end
            if (take && hwrite) begin
                state_ff <= csp_pkg::CSP_ST_WRITE;
            end else if (take) begin
                state_ff <= csp_pkg::CSP_ST_READ;
            end else if (hready) begin
                state_ff <= csp_pkg::CSP_ST_IDLE;
            end
        end
    end
    logic wr;
    assign wr = (state_ff == csp_pkg::CSP_ST_WRITE);

    // ----------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------
    // each word but the port data and status words carries a pair of 16-bit registers and a word write
    // fills both halves; a halfword write would clobber its partner,
    // so software keeps to word writes
    // the status word has no strobe: it is read-only and a write to
    // it lands nowhere
    logic wr_pinsel;
    logic wr_boot;
    logic wr_port;
    logic [`CSP_NUM_GEN - 1:0] wr_gen;
    assign wr_pinsel = wr && hits(addr_ff, `CSP_OFF_PINSEL_LO);
    assign wr_boot = wr && hits(addr_ff, `CSP_OFF_BOOT_BASE);
    assign wr_port = wr && hits(addr_ff, `CSP_OFF_PORT_DATA);

    // 16-bit registers sit in halfword pairs; the word-aligned one in
    // bits 15:0, the +2 one in bits 31:16, as a 32-bit bus carries them
    function automatic logic hits(input logic [11:0] a,
                                  input logic [11:0] off);
        hits = (a[11:2] == off[11:2]);
    endfunction
    function automatic logic [15:0] lane(input logic [11:0] off,
                                         input logic [31:0] d);
        lane = off[1] ? d[31:16] : d[15:0];
    endfunction

    // ----------------------------------------------------------
    // pin assignment registers
    // ----------------------------------------------------------
    logic [15:0] pinsel_lo_ff;
    logic [15:0] pinsel_hi_ff;
    logic [15:0] lo_rst;
    logic [15:0] hi_rst;
    logic [4:0] hi_cs_keep;
    always_comb begin
        lo_rst = 16'h0000;
        // fields six..four from strap two, three..one from strap one
        lo_rst[13:2] = {strap_sync_ff[2], 1'b1, strap_sync_ff[2], 1'b1,
                        strap_sync_ff[2], 1'b1, strap_sync_ff[1], 1'b1,
                        strap_sync_ff[1], 1'b1,
                        strap_sync_ff[1], 1'b1};
        lo_rst[1] = 1'b1;
        lo_rst[0] = strap_sync_ff[0];
        // a low strap also turns every lower-numbered pin down to pin 7 to address
        hi_cs_keep[4] = strap_sync_ff[7];
        for (int i = 3; i >= 0; i--) begin
            hi_cs_keep[i] = hi_cs_keep[i + 1] & strap_sync_ff[i + 3];
        end
        hi_rst = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            hi_rst[2 * i + 1] = hi_cs_keep[i];
            hi_rst[2 * i] = 1'b1;
        end
    end
    // bit 1 is one even before the straps land, so the boot pin
    // never leaves select use, not even in the capture window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pinsel_lo_ff <= `CSP_LO_FORCE;
        end else if (strap_load) begin
            pinsel_lo_ff <= lo_rst;
        end else if (wr_pinsel) begin
            pinsel_lo_ff <= (lane(`CSP_OFF_PINSEL_LO, hwdata) & `CSP_LO_KEEP)
                            | `CSP_LO_FORCE;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pinsel_hi_ff <= 16'h0000;
        end else if (strap_load) begin
            pinsel_hi_ff <= hi_rst;
        end else if (wr_pinsel) begin
            pinsel_hi_ff <= lane(`CSP_OFF_PINSEL_HI, hwdata)
                            & `CSP_HI_KEEP;
        end
    end

    // ----------------------------------------------------------
    // boot and general base / option registers
    // ----------------------------------------------------------
    logic [15:0] boot_base_ff;
    logic [15:0] boot_opt_ff;
    logic [15:0] gen_base_ff [`CSP_NUM_GEN];
    logic [15:0] gen_opt_ff [`CSP_NUM_GEN];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_base_ff <= `CSP_BOOT_BASE_RST;
        end else if (wr_boot) begin
            boot_base_ff <= lane(`CSP_OFF_BOOT_BASE, hwdata);
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_opt_ff <= `CSP_BOOT_OPT_RST;
        end else if (wr_boot) begin
            boot_opt_ff <= lane(`CSP_OFF_BOOT_OPT, hwdata);
        end
    end
    genvar g;
    generate
        for (g = 0; g < `CSP_NUM_GEN; g++) begin : gen_ch
            localparam logic [11:0] OFF = `CSP_OFF_GEN_BASE0 + 12'(4 * g);
            // one strobe per channel, decoded from the channel's word
            assign wr_gen[g] = wr && hits(addr_ff, OFF);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    gen_base_ff[g] <= `CSP_GEN_RST;
                end else if (wr_gen[g]) begin
                    gen_base_ff[g] <= lane(OFF, hwdata);
                end
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    gen_opt_ff[g] <= `CSP_GEN_RST;
                end else if (wr_gen[g]) begin
                    gen_opt_ff[g] <= lane(OFF + 12'h002, hwdata);
                end
            end
            // nonzero byte field (lower, upper or both) enables it
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    channel_enable[g] <= 1'b0;
                end else begin
                    channel_enable[g] <= csp_pkg::csp_byte_t'(
                        gen_opt_ff[g][`CSP_BYTE_MSB:`CSP_BYTE_LSB])
                        != csp_pkg::CSP_BYTE_OFF;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------
    // discrete output data register
    // ----------------------------------------------------------
    // bits 2:0 feed pins 6..4, bits 6:3 pins 10..7
    logic [6:0] port_data_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_data_ff <= `CSP_PORT_RST;
        end else if (wr_port) begin
            port_data_ff <= hwdata[6:0];
        end
    end

    // short-address parts mirror line 19 up, halving the boot block
    logic [2:0] boot_blk_eff;
    assign boot_blk_eff = (`CSP_SHORT_ADDR
                           && boot_base_ff[2:0] == `CSP_BLK_1M)
                          ? `CSP_BLK_512K : boot_base_ff[2:0];

    // ----------------------------------------------------------
    // read data
    // ----------------------------------------------------------
    // the read word is held until the next read is taken, so a
    // master that samples late still sees the word it asked for
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (hits(addr_ff, `CSP_OFF_PINSEL_LO)) begin
            nxt_rdata = {pinsel_hi_ff, pinsel_lo_ff};
        end else if (hits(addr_ff, `CSP_OFF_BOOT_BASE)) begin
            nxt_rdata = {boot_opt_ff, boot_base_ff};
        end else if (hits(addr_ff, `CSP_OFF_PORT_DATA)) begin
            nxt_rdata = {25'h0, port_data_ff};
        end else if (hits(addr_ff, `CSP_OFF_STATUS)) begin
            nxt_rdata = {13'h0, boot_blk_eff, 5'h0, channel_enable};
        end
        for (int i = 0; i < `CSP_NUM_GEN; i++) begin
            if (addr_ff[11:2] == 10'(({22'h0, `CSP_OFF_GEN_BASE0} + 4 * i)
                                     >> 2)) begin
                nxt_rdata = {gen_opt_ff[i], gen_base_ff[i]};
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= 32'h0000_0000;
        end else if (state_ff == csp_pkg::CSP_ST_READ) begin
            hrdata <= nxt_rdata;
        end
    end
    // one wait state on reads so the read data comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !(take && !hwrite);
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // pin multiplexers
    // ----------------------------------------------------------
    logic [23:0] fields;
    logic [11:0] disc_src;
    logic [11:0] alt_src;
    // pins: 0 boot, 1..11 general selects 0..10
    assign fields = {pinsel_hi_ff[9:0], pinsel_lo_ff[13:0]};
    // no discrete on boot and selects 2..0: code 00 left to software
    assign disc_src = {slow_bus_eclock, port_data_ff[6:3],
                       port_data_ff[2:0], 3'h7, 1'b1};
    assign alt_src = {addr_src, function_code_line,
                      bus_grant_acknowledge, bus_grant, bus_request,
                      1'b1};
    generate
        for (g = 0; g < `CSP_NUM_PINS; g++) begin : gen_pin
            csp_pin_mux u_mux (
                .hclk(hclk),
                .hresetn(hresetn),
                .fn(fields[2 * g +: 2]),
                .discrete_src(disc_src[g]),
                .alternate_src(alt_src[g]),
                .select_src(select_src[g]),
                .pin_ff(select_pin[g]),
                .is_select_ff(select_mode[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// [hdl/csp_map.svh]
// register offsets, field positions, reset values of the select pin unit
// assumes: included by design files by bare name
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH

// --------------------------------------------------------------
// byte offsets on the register bus
// --------------------------------------------------------------
`define CSP_OFF_PINSEL_LO 12'h044
`define CSP_OFF_PINSEL_HI 12'h046
`define CSP_OFF_BOOT_BASE 12'h048
`define CSP_OFF_BOOT_OPT 12'h04A
`define CSP_OFF_GEN_BASE0 12'h04C
`define CSP_OFF_GEN_OPT0 12'h04E
`define CSP_OFF_GEN_LAST 12'h076
`define CSP_OFF_PORT_DATA 12'h080
`define CSP_OFF_STATUS 12'h084

// --------------------------------------------------------------
// field layouts and reset values
// --------------------------------------------------------------
`define CSP_NUM_GEN 11
`define CSP_NUM_PINS 12
`define CSP_LO_KEEP 16'h3FFD
`define CSP_LO_FORCE 16'h0002
`define CSP_HI_KEEP 16'h03FF
`define CSP_BYTE_MSB 14
`define CSP_BYTE_LSB 13
`define CSP_BOOT_BASE_RST 16'h0007
`define CSP_BOOT_OPT_RST 16'h7B70
`define CSP_GEN_RST 16'h0000
`define CSP_PORT_RST 7'h7F
`define CSP_BLK_1M 3'h7
`define CSP_BLK_512K 3'h6
`define CSP_SHORT_ADDR 1'h0

`endif

// [hdl/csp_pkg.sv]
// types shared by the select pin unit
// assumes: compiled before the design modules
package csp_pkg;
    typedef enum logic [1:0] {
        CSP_FN_DISCRETE = 2'h0,
        CSP_FN_ALTERNATE = 2'h1,
        CSP_FN_SELECT8 = 2'h2,
        CSP_FN_SELECT16 = 2'h3
    } csp_fn_t;
    typedef enum logic [1:0] {
        CSP_BYTE_OFF = 2'h0,
        CSP_BYTE_LOWER = 2'h1,
        CSP_BYTE_UPPER = 2'h2,
        CSP_BYTE_BOTH = 2'h3
    } csp_byte_t;
    typedef enum logic [2:0] {
        CSP_ST_IDLE = 3'b001,
        CSP_ST_WRITE = 3'b010,
        CSP_ST_READ = 3'b100
    } csp_state_t;
endpackage

// [hdl/csp_pin_mux.sv]
// one pin output multiplexer steered by its 2-bit function field
// assumes: sources are on hclk; result registered one edge later
`timescale 1ns/100ps
`default_nettype none
module csp_pin_mux (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] fn,
    input wire logic discrete_src,
    input wire logic alternate_src,
    input wire logic select_src,
    output logic pin_ff,
    output logic is_select_ff
);
    logic nxt_pin;

    always_comb begin
        unique case (csp_pkg::csp_fn_t'(fn))
            csp_pkg::CSP_FN_DISCRETE: nxt_pin = discrete_src;
            csp_pkg::CSP_FN_ALTERNATE: nxt_pin = alternate_src;
            csp_pkg::CSP_FN_SELECT8: nxt_pin = select_src;
            csp_pkg::CSP_FN_SELECT16: nxt_pin = select_src;
        endcase
    end

    // select pins idle high, so the reset level is inactive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_ff <= 1'b1;
            is_select_ff <= 1'b1;
        end else begin
            pin_ff <= nxt_pin;
            is_select_ff <= fn[1];
        end
    end
endmodule
`default_nettype wire

// [verification/csp_pin_assign_assertions.sv]
// checker of the select pin unit, bound to its top module
// assumes: one hclk domain, hready tied back from hreadyout
`timescale 1ns/100ps
`default_nettype none
module csp_pin_assign_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [11:0] select_src,
    input wire logic [11:0] select_pin,
    input wire logic [11:0] select_mode,
    input wire logic [10:0] channel_enable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] live_ff;
    logic rd;
    logic wr;
    // --------------------------------------------------------------
    // helper logic
    // --------------------------------------------------------------
    // straps land a few edges after release, so pin checks wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live_ff <= 3'h0;
        end else if (live_ff != 3'h7) begin
            live_ff <= live_ff + 3'h1;
        end
    end
    assign rd = hsel && hready && htrans[1] && !hwrite;
    assign wr = hsel && hready && htrans[1] && hwrite;
    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    a_resp_okay:
    assert property (hresp == 1'h0) else $error("response not okay");
    a_read_wait:
    assert property (rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    a_write_nowait:
    assert property (wr |=> hreadyout) else $error("write stalled");
    a_assign_fixed:
    assert property (rd && haddr[11:0] == 12'h044 |=> ##1
        (hrdata[31:26] == 6'h0 && hrdata[15:14] == 2'h0 && hrdata[1]))
        else $error("fixed assignment bits wrong");
    a_unmapped_zero:
    assert property (rd && haddr[11:0] == 12'h100 |=> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_select_follow:
    assert property (live_ff == 3'h7 |->
        (select_pin & select_mode) == ($past(select_src) & select_mode))
        else $error("select pin not following source");
    a_boot_select:
    assert property (live_ff == 3'h7 |-> select_mode[0])
        else $error("boot pin left select use");
    a_mode_cause:
    assert property (live_ff == 3'h7 && $changed(select_mode) |->
        $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
        else $error("pin mode changed without write");
    a_enable_status:
    assert property (rd && haddr[11:0] == 12'h084 |=> ##1
        (channel_enable != $past(channel_enable, 2) ||
        hrdata[10:0] == channel_enable))
        else $error("status enable bits wrong");
    c_read_assign: cover property (rd && haddr[11:0] == 12'h044);
    c_enable: cover property (|channel_enable);
    c_alt_mode: cover property (select_mode != 12'hFFF);
endmodule
`default_nettype wire

// [verification/csp_select_partner.sv]
// far side: strap pull-ups and parts watching the select pins
// assumes: a strap line floats high unless a part holds it low
`timescale 1ns/100ps
`default_nettype none
module csp_select_partner (
    input wire logic hclk,
    input wire logic [7:0] strap_low,
    input wire logic [11:0] select_pin,
    output logic [7:0] strap_data,
    output logic [11:0] selects_seen
);
    // weak pull-up wins on every line not held low
    assign strap_data = ~strap_low;
    initial selects_seen = 12'h000;
    // sticky record of pins seen low, for a look in the waveform
    always @(posedge hclk) begin
        selects_seen <= selects_seen | ~select_pin;
    end
endmodule
`default_nettype wire

// [verification/test_chip_select_reset_and_pin_assign.sv]
// testbench of the select pin unit: strap resets, registers, pin mux
// assumes: design, checker and partner compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) \
    begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %s exp %h got %h", n, e, a); end end
module test_chip_select_reset_and_pin_assign;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rdat;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, fcl = 3'h0;
    logic hreadyout, hresp, brq = 1'h0, bgr = 1'h0, bga = 1'h0, eck = 1'h0;
    logic [7:0] strap_data, strap_low = 8'h00;
    logic [11:0] select_src = 12'hFFF, select_pin, select_mode;
    logic [23:19] addr_src = 5'h00;
    logic [10:0] channel_enable;
    logic [31:0] seed = 32'h808D;
    int num_errors = 0, checks = 0, cyc = 0;
    csp_pin_assign dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .strap_data, .select_src, .addr_src, .function_code_line(fcl),
        .bus_request(brq), .bus_grant(bgr), .bus_grant_acknowledge(bga),
        .slow_bus_eclock(eck), .select_pin, .select_mode, .channel_enable);
    csp_select_partner far_u (.hclk, .strap_low, .select_pin, .strap_data,
        .selects_seen());
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    initial forever #50 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            stop_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // s is the strap level seen by the device, high when released
    function automatic logic [31:0] exp_assign(input logic [7:0] s);
        logic [15:0] lo;
        logic [15:0] hi;
        lo = {2'h0, {3{s[2], 1'h1}}, {3{s[1], 1'h1}}, 1'h1, s[0]};
        hi = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            hi[2*i +: 2] = {&(s[7:3] | ~(5'h1F << i)), 1'h1};
        end
        return {hi, lo};
    endfunction
    function automatic logic xpin(input int p, input logic [1:0] f,
        input logic [6:0] port);
        logic [11:0] dis;
        logic [11:0] alt;
        dis = {eck, port[6:3], port[2:0], 4'hF};
        alt = {addr_src, fcl, bga, bgr, brq, 1'h1};
        return f[1] ? select_src[p] : (f[0] ? alt[p] : dis[p]);
    endfunction
    task automatic bus(input logic w, input logic [31:0] a, d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rdat = hrdata;
    endtask
    task automatic do_reset(input logic [7:0] low);
        strap_low <= low;
        hresetn <= 1'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (5) @(posedge hclk);
    endtask
    task automatic check_pins(input logic [23:0] f, input logic [6:0] port);
        for (int p = 0; p < 12; p++) begin
            `CHK("pin", xpin(p, f[2*p+:2], port), select_pin[p])
            `CHK("mode", f[2*p+1], select_mode[p])
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        logic [31:0] w, p, r;
        logic [7:0] s;
        logic [10:0] en;
        for (int t = 0; t < 4; t++) begin
            r = rnd();
            s = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : r[7:0];
            do_reset(s);
            bus(1'h0, 32'h44, 32'h0);
            `CHK("assign", exp_assign(~s), rdat)
            w = exp_assign(~s);
            check_pins({w[25:16], w[13:0]}, 7'h7F);
            bus(1'h0, 32'h48, 32'h0);
            `CHK("boot", 32'h7B70_0007, rdat)
            for (int n = 0; n < 11; n++) begin
                bus(1'h0, 32'h4C + 4 * n, 32'h0);
                `CHK("general", 32'h0, rdat)
            end
            bus(1'h0, 32'h80, 32'h0);
            `CHK("port", 32'h7F, rdat)
            bus(1'h0, 32'h84, 32'h0);
            `CHK("status", 32'h0007_0000, rdat)
            bus(1'h1, 32'h100, 32'hFFFF_FFFF);
            bus(1'h0, 32'h100, 32'h0);
            `CHK("unmapped", 32'h0, rdat)
        end
        repeat (8) begin
            w = rnd() | 32'h0000_0054;
            p = rnd();
            bus(1'h1, 32'h44, w);
            bus(1'h1, 32'h80, p);
            r = rnd();
            {select_src, addr_src, fcl, bga, bgr, brq, eck} <= r[23:0];
            bus(1'h0, 32'h44, 32'h0);
            w = {w[31:16] & 16'h03FF, (w[15:0] & 16'h3FFD) | 16'h0002};
            `CHK("assign", w, rdat)
            bus(1'h0, 32'h80, 32'h0);
            `CHK("port", {25'h0, p[6:0]}, rdat)
            check_pins({w[25:16], w[13:0]}, p[6:0]);
        end
        en = 11'h000;
        for (int n = 0; n < 11; n++) begin
            w = rnd();
            w[30:29] = n[1:0];
            en[n] = |w[30:29];
            bus(1'h1, 32'h4C + 4 * n, w);
            bus(1'h0, 32'h4C + 4 * n, 32'h0);
            `CHK("byte", w[30:29], rdat[30:29])
        end
        bus(1'h0, 32'h84, 32'h0);
        `CHK("status", {13'h0, 3'h7, 5'h0, en}, rdat)
        `CHK("enable", en, channel_enable)
        stop_test();
    end
endmodule
bind csp_pin_assign csp_pin_assign_checker chk_u (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .select_src, .select_pin, .select_mode, .channel_enable);
`default_nettype wire
